// >>> shared/front_panel_defs.svh
// constants for the front-panel configuration controller
// assumes a 125 MHz system clock; included by bare name
`ifndef FRONT_PANEL_DEFS_SVH
`define FRONT_PANEL_DEFS_SVH

// clock rate in kHz, so that ms * kHz gives cycles
`define FP_CLK_KHZ 125000
// contact settle time, ms
`define FP_DEBOUNCE_MS 10
`define FP_DEBOUNCE_CYC (`FP_DEBOUNCE_MS * `FP_CLK_KHZ)
// paddle hold time before acceleration, ms
`define FP_ACCEL_MS 500
`define FP_ACCEL_CYC (`FP_ACCEL_MS * `FP_CLK_KHZ)
// full traverse time of a wide parameter, ms, and its step count
`define FP_RANGE_MS 10000
`define FP_RANGE_STEPS 256
`define FP_REPEAT_CYC ((`FP_RANGE_MS * `FP_CLK_KHZ) / `FP_RANGE_STEPS)
// how long the configuring indicator stays lit per change, ms
`define FP_CONFIGURING_LED_MS 20
`define FP_CONFIGURING_LED_CYC (`FP_CONFIGURING_LED_MS * `FP_CLK_KHZ)

// rotary layout
`define FP_POSITIONS 16
`define FP_BANK_COUNT 2'd3
`define FP_BANK_FIRST 2'd0
`define FP_BANK_SECOND 2'd1
`define FP_POS_PARK 4'h0
`define FP_POS_LAST 4'hf
`define FP_POS_OSD 4'h1
`define FP_POS_EDH 4'h3
`define FP_POS_HANC 4'h4
`define FP_POS_TEST 4'hc
`define FP_POS_HTIME 4'hb
`define FP_POS_VTIME 4'hc

// channel setting bits
`define FP_BIT_OSD 0
`define FP_BIT_EDH 1
`define FP_BIT_HANC 2
`define FP_BIT_TEST 3
// osd off, edh on, hanc pass, test off
`define FP_CH_RESET 4'h2

// register port offsets
`define FP_REG_STATUS 8'h00
`define FP_REG_CH0 8'h04
`define FP_REG_CH1 8'h08
`define FP_REG_CH2 8'h0c
`define FP_REG_CH3 8'h10

`endif

// >>> shared/front_panel_pkg.sv
// types shared by the front-panel controller and its testbench
// no dependencies
package front_panel_pkg;

    // one channel's local settings, bit order as in the defs header
    typedef struct packed {
        logic test_on;
        logic hanc_blank;
        logic edh_on;
        logic osd_on;
    } chan_cfg_t;

    // raw operator inputs, active high
    typedef struct packed {
        logic [3:0] rotary;
        logic paddle_up;
        logic paddle_down;
        logic mode_button;
    } panel_in_t;

    // paddle assignment
    typedef enum logic [1:0] {
        MODE_PARAM = 2'b01,
        MODE_CHSEL = 2'b10
    } paddle_mode_t;

endpackage : front_panel_pkg

// >>> hw/contact_debounce.sv
// single-contact debouncer
// input is synchronous to clk; reset is the already released copy
`timescale 1ns/100ps
`default_nettype none
module contact_debounce #(
    parameter logic [20:0] SETTLE_CYC = 21'd1250000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic raw,
    output logic clean
);
    logic [20:0] cnt_q;

    // output follows only after the raw level has held for the settle time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 21'h000000;
            clean <= 1'b0;
        end else if (raw == clean) begin
            cnt_q <= 21'h000000;
        end else if (cnt_q >= SETTLE_CYC - 21'd1) begin
            cnt_q <= 21'h000000;
            clean <= raw;
        end else begin
            cnt_q <= cnt_q + 21'd1;
        end
    end
endmodule : contact_debounce
`default_nettype wire

// >>> hw/paddle_repeat.sv
// paddle step generator: one step per press, auto-repeat after a long hold on a wide parameter
// held is a debounced level; wide selects parameters of 256 or more values
`timescale 1ns/100ps
`default_nettype none
module paddle_repeat #(
    parameter logic [25:0] ACCEL_CYC = 26'd62500000,
    parameter logic [25:0] REPEAT_CYC = 26'd4882812
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic held,
    input wire logic wide,
    output logic step
);
    logic [25:0] cnt_q;
    logic held_q;
    logic accel_q;

    // first step on press; repeats only while accelerated and wide
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 26'h0000000;
            held_q <= 1'b0;
            accel_q <= 1'b0;
            step <= 1'b0;
        end else begin
            held_q <= held;
            step <= 1'b0;
            if (!held) begin
                cnt_q <= 26'h0000000;
                accel_q <= 1'b0;
            end else if (!held_q) begin
                step <= 1'b1;
                cnt_q <= 26'h0000000;
            end else if (!accel_q && cnt_q >= ACCEL_CYC - 26'd1) begin
                accel_q <= 1'b1;
                cnt_q <= 26'h0000000;
                step <= wide;
            end else if (accel_q && cnt_q >= REPEAT_CYC - 26'd1) begin
                cnt_q <= 26'h0000000;
                step <= wide;
            end else begin
                cnt_q <= cnt_q + 26'd1;
            end
        end
    end
endmodule : paddle_repeat
`default_nettype wire

// >>> hw/front_panel_config_controller.sv
// front-panel configuration controller for a four-channel synchronizer
// switches and jumpers are synchronous to clk; register port is a plain slave
`include "front_panel_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module front_panel_config_controller
    import front_panel_pkg::*;
#(
    parameter logic [20:0] DEBOUNCE_CYC = 21'(`FP_DEBOUNCE_CYC),
    parameter logic [25:0] ACCEL_CYC = 26'(`FP_ACCEL_CYC),
    parameter logic [25:0] REPEAT_CYC = 26'(`FP_REPEAT_CYC),
    parameter logic [21:0] CONFIGURING_LED_CYC = 22'(`FP_CONFIGURING_LED_CYC)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire panel_in_t panel,
    input wire logic remote_access_jumper,
    input wire logic display_control_jumper,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    output logic bank_indicator_led,
    output logic channel_select_led,
    output logic channel_code_high_led,
    output logic channel_code_low_led,
    output logic configuring_led,
    output chan_cfg_t [3:0] channel_settings,
    output logic [3:0] on_screen_display,
    output logic [1:0] display_bank,
    output logic [3:0] display_position,
    output logic [1:0] display_channel,
    output logic adjust_up,
    output logic adjust_down
);
    localparam int NIN = 7;

    logic rst_meta_q;
    logic rst_sync_q;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] clean_in;
    logic [3:0] rot_now;
    logic [3:0] rot_q;
    logic pad_up;
    logic pad_dn;
    logic btn_now;
    logic btn_q;
    logic step_up;
    logic step_dn;
    logic wide_now;
    logic [1:0] bank_q;
    logic [1:0] chan_q;
    paddle_mode_t mode_q;
    chan_cfg_t [3:0] cfg_q;
    logic [2:0] b1_dec;
    logic [2:0] reg_dec;
    logic local_hit;
    logic [1:0] local_bit;
    logic local_val;
    logic remote_hit;
    logic [1:0] remote_ch;
    logic changed;
    logic [21:0] configuring_led_cnt_q;

    // does this bank/position hold a parameter of 256 or more values
    function automatic logic is_wide(input logic [1:0] bank, input logic [3:0] pos);
        is_wide = (bank == `FP_BANK_SECOND) && (pos == `FP_POS_HTIME || pos == `FP_POS_VTIME);
    endfunction : is_wide

    // which setting bit a first-bank position drives; valid flag in msb
    function automatic logic [2:0] bank1_bit(input logic [3:0] pos);
        case (pos)
            `FP_POS_OSD: bank1_bit = {1'b1, 2'(`FP_BIT_OSD)};
            `FP_POS_EDH: bank1_bit = {1'b1, 2'(`FP_BIT_EDH)};
            `FP_POS_HANC: bank1_bit = {1'b1, 2'(`FP_BIT_HANC)};
            `FP_POS_TEST: bank1_bit = {1'b1, 2'(`FP_BIT_TEST)};
            default: bank1_bit = 3'h0;
        endcase
    endfunction : bank1_bit

    // register offset to channel index; valid flag in msb
    function automatic logic [2:0] chan_reg(input logic [7:0] addr);
        case (addr)
            `FP_REG_CH0: chan_reg = 3'h4;
            `FP_REG_CH1: chan_reg = 3'h5;
            `FP_REG_CH2: chan_reg = 3'h6;
            `FP_REG_CH3: chan_reg = 3'h7;
            default: chan_reg = 3'h0;
        endcase
    endfunction : chan_reg

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign raw_in = {panel.rotary, panel.paddle_up, panel.paddle_down, panel.mode_button};

    // debounce every contact
    // rotary bits settle separately, so a bit-skew glitch costs one settle time
    generate
        for (genvar i = 0; i < NIN; i++) begin : g_db
            contact_debounce #(
                .SETTLE_CYC(DEBOUNCE_CYC)
            ) u_db (
                .clk(clk),
                .rst_n(rst_sync_q),
                .raw(raw_in[i]),
                .clean(clean_in[i])
            );
        end
    endgenerate

    assign rot_now = clean_in[6:3];
    // both directions at once counts as neither
    assign pad_up = clean_in[2] & ~clean_in[1];
    assign pad_dn = clean_in[1] & ~clean_in[2];
    assign btn_now = clean_in[0];
    assign wide_now = is_wide(bank_q, rot_q);

    paddle_repeat #(
        .ACCEL_CYC(ACCEL_CYC),
        .REPEAT_CYC(REPEAT_CYC)
    ) u_rep_up (
        .clk(clk),
        .rst_n(rst_sync_q),
        .held(pad_up),
        .wide(wide_now),
        .step(step_up)
    );

    paddle_repeat #(
        .ACCEL_CYC(ACCEL_CYC),
        .REPEAT_CYC(REPEAT_CYC)
    ) u_rep_dn (
        .clk(clk),
        .rst_n(rst_sync_q),
        .held(pad_dn),
        .wide(wide_now),
        .step(step_dn)
    );

    // wrap past zero forward or back through F moves the bank
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rot_q <= `FP_POS_PARK;
            bank_q <= `FP_BANK_FIRST;
        end else begin
            rot_q <= rot_now;
            if (rot_q == `FP_POS_LAST && rot_now == `FP_POS_PARK) begin
                bank_q <= (bank_q == `FP_BANK_COUNT - 2'd1) ? `FP_BANK_FIRST : bank_q + 2'd1;
            end else if (rot_q == `FP_POS_PARK && rot_now == `FP_POS_LAST) begin
                bank_q <= (bank_q == `FP_BANK_FIRST) ? `FP_BANK_COUNT - 2'd1 : bank_q - 2'd1;
            end
        end
    end

    // button press edge toggles paddle mode
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            btn_q <= 1'b0;
            mode_q <= MODE_PARAM;
        end else begin
            btn_q <= btn_now;
            if (btn_now && !btn_q) begin
                case (mode_q)
                    MODE_PARAM: mode_q <= MODE_CHSEL;
                    MODE_CHSEL: mode_q <= MODE_PARAM;
                    default: mode_q <= MODE_PARAM;
                endcase
            end
        end
    end

    // channel-select mode steps the active channel, wrapping at four
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            chan_q <= 2'h0;
        end else if (mode_q == MODE_CHSEL) begin
            if (step_up) begin
                chan_q <= chan_q + 2'd1;
            end else if (step_dn) begin
                chan_q <= chan_q - 2'd1;
            end
        end
    end

    // local paddle action decode
    // parked position excluded
    // unused positions decode to no bit
    always_comb begin
        local_bit = b1_dec[1:0];
        local_val = step_up;
        local_hit = (mode_q == MODE_PARAM) && (bank_q == `FP_BANK_FIRST)
                    && (rot_q != `FP_POS_PARK) && b1_dec[2] && (step_up || step_dn);
        // display control gated by its jumper
        if (local_bit == 2'(`FP_BIT_OSD) && !display_control_jumper) begin
            local_hit = 1'b0;
        end
    end

    // remote writes need the local-and-remote jumper position
    assign b1_dec = bank1_bit(rot_q);
    assign reg_dec = chan_reg(reg_addr);
    assign remote_hit = reg_we && reg_dec[2] && remote_access_jumper;
    assign remote_ch = reg_dec[1:0];

    // channel settings; local action wins a same-cycle collision on its bit
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            for (int c = 0; c < 4; c++) begin
                cfg_q[c] <= `FP_CH_RESET;
            end
        end else begin
            // remote may switch each channel's display separately while the display jumper is on
            if (remote_hit) begin
                cfg_q[remote_ch] <= chan_cfg_t'(reg_wdata[3:0]);
                if (!display_control_jumper) begin
                    cfg_q[remote_ch].osd_on <= cfg_q[remote_ch].osd_on;
                end
            end
            // local change lands on the active channel only
            // up on, down off for the display bit
            // up on, down off for new error data
            // up blanks, down passes ancillary data
            // up on, down off for the test signal
            if (local_hit) begin
                cfg_q[chan_q][local_bit] <= local_val;
            end
        end
    end

    assign changed = local_hit || remote_hit;

    // configuring indicator held while new settings are programmed
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            configuring_led_cnt_q <= 22'h000000;
            configuring_led <= 1'b0;
        end else if (changed) begin
            configuring_led_cnt_q <= CONFIGURING_LED_CYC;
            configuring_led <= 1'b1;
        end else if (configuring_led_cnt_q != 22'h000000) begin
            configuring_led_cnt_q <= configuring_led_cnt_q - 22'd1;
            configuring_led <= (configuring_led_cnt_q != 22'd1);
        end else begin
            configuring_led <= 1'b0;
        end
    end

    // indicator leds, all registered
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            bank_indicator_led <= 1'b0;
            channel_select_led <= 1'b0;
            channel_code_high_led <= 1'b0;
            channel_code_low_led <= 1'b0;
        end else begin
            // lit for the second bank only
            bank_indicator_led <= (bank_q == `FP_BANK_SECOND);
            channel_select_led <= (mode_q == MODE_CHSEL);
            // binary channel code, high led first
            channel_code_high_led <= chan_q[1];
            channel_code_low_led <= chan_q[0];
        end
    end

    // video-side outputs and display generator feed
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            channel_settings <= {4{chan_cfg_t'(`FP_CH_RESET)}};
            on_screen_display <= 4'h0;
            display_bank <= `FP_BANK_FIRST;
            display_position <= `FP_POS_PARK;
            display_channel <= 2'h0;
            adjust_up <= 1'b0;
            adjust_down <= 1'b0;
        end else begin
            channel_settings <= cfg_q;
            // jumper off forces insertion off everywhere
            for (int c = 0; c < 4; c++) begin
                on_screen_display[c] <= cfg_q[c].osd_on & display_control_jumper;
            end
            // current function and channel go to the display
            // position zero of bank one selects the identity page
            display_bank <= bank_q;
            display_position <= rot_q;
            display_channel <= chan_q;
            // wide-range steps leave for the parameter owner
            adjust_up <= step_up && wide_now && (mode_q == MODE_PARAM);
            adjust_down <= step_dn && wide_now && (mode_q == MODE_PARAM);
        end
    end

    // register read, data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_re) begin
            if (reg_addr == `FP_REG_STATUS) begin
                reg_rdata <= {20'h00000, display_control_jumper, remote_access_jumper,
                              configuring_led, mode_q == MODE_CHSEL, chan_q, bank_q, rot_q};
            end else if (reg_dec[2]) begin
                reg_rdata <= {28'h0000000, cfg_q[reg_dec[1:0]]};
            end else begin
                reg_rdata <= 32'h00000000;
            end
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule : front_panel_config_controller
`default_nettype wire

// >>> tb/panel_operator.sv
// operator model: moves the rotary, paddle and mode button by hand
// assumes the bench calls its tasks one at a time; contacts bounce before settling
`timescale 1ns/100ps
`default_nettype none
module panel_operator
    import front_panel_pkg::*;
(
    input wire logic clk,
    output var panel_in_t panel
);
    initial panel = '0;

    // contacts bounce
    // glitches shorter than the settle time, so a clean move counts once
    task automatic move(input panel_in_t target);
        panel_in_t prev;
        prev = panel;
        repeat (2) begin
            @(posedge clk) panel <= target;
            @(posedge clk) panel <= prev;
        end
        @(posedge clk) panel <= target;
        repeat (12) @(posedge clk);
    endtask : move

    task automatic turn();
        panel_in_t t;
        t = panel;
        t.rotary = t.rotary + 4'h1;
        move(t);
    endtask : turn

    task automatic paddle(input logic up, input int hold);
        panel_in_t t;
        t = panel;
        t.paddle_up = up;
        t.paddle_down = !up;
        move(t);
        repeat (hold) @(posedge clk);
        t.paddle_up = 1'b0;
        t.paddle_down = 1'b0;
        move(t);
    endtask : paddle

    // one press of the mode button
    task automatic button();
        panel_in_t t;
        t = panel;
        t.mode_button = 1'b1;
        move(t);
        t.mode_button = 1'b0;
        move(t);
    endtask : button
endmodule : panel_operator
`default_nettype wire

// >>> tb/front_panel_chk.sv
// port assertions for the front-panel controller
// one clock domain; bound into every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module front_panel_chk
    import front_panel_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic display_control_jumper,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [31:0] reg_rdata,
    input wire logic bank_indicator_led,
    input wire logic channel_select_led,
    input wire logic channel_code_high_led,
    input wire logic channel_code_low_led,
    input wire logic configuring_led,
    input wire chan_cfg_t [3:0] channel_settings,
    input wire logic [3:0] on_screen_display,
    input wire logic [1:0] display_bank,
    input wire logic [3:0] display_position,
    input wire logic [1:0] display_channel,
    input wire logic adjust_up,
    input wire logic adjust_down
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // display insertion off while the jumper is off
    a_osd_jumper_off:
        assert property ((!display_control_jumper) [*3] |-> on_screen_display == 4'h0)
        else $error("display shown with jumper off");
    // quiet window in channel-select mode keeps settings frozen
    a_chsel_frozen:
        assert property ((channel_select_led && !reg_we) [*4] |=> $stable(channel_settings))
        else $error("setting changed in channel-select mode");
    a_park_frozen:
        assert property ((display_position == 4'h0 && !reg_we) [*4] |=> $stable(channel_settings))
        else $error("setting changed at parked position");
    a_configuring_led_on_change:
        assert property ($changed(channel_settings) |-> configuring_led)
        else $error("setting changed without configuring led");
    a_configuring_led_stretch:
        assert property ($rose(configuring_led) |-> configuring_led [*4])
        else $error("configuring led too short");
    // wide adjust pulses only at bank two timing positions, parameter mode
    a_adjust_scope:
        assert property (adjust_up || adjust_down |-> display_bank == 2'd1 && !channel_select_led
                         && (display_position == 4'hb || display_position == 4'hc))
        else $error("adjust pulse outside wide functions");
    a_adjust_pulse:
        assert property (adjust_up |=> !adjust_up && !adjust_down)
        else $error("adjust pulse too long");
    a_bank_led_match:
        assert property ($rose(bank_indicator_led) |-> ##[0:1] display_bank == 2'd1)
        else $error("bank led lit outside second bank");
    a_chan_led_code:
        assert property ($changed({channel_code_high_led, channel_code_low_led})
                         |-> ##[0:1] display_channel == {channel_code_high_led, channel_code_low_led})
        else $error("channel leds disagree with channel");
    a_rdata_idle:
        assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");

    c_bank_two: cover property ($rose(bank_indicator_led));
    c_adjust: cover property (adjust_up);
    c_configuring_led: cover property ($rose(configuring_led));
endmodule : front_panel_chk

bind front_panel_config_controller front_panel_chk chk_u (
    .clk(clk), .rst_n(rst_n), .display_control_jumper(display_control_jumper), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .bank_indicator_led(bank_indicator_led),
    .channel_select_led(channel_select_led), .channel_code_high_led(channel_code_high_led),
    .channel_code_low_led(channel_code_low_led), .configuring_led(configuring_led),
    .channel_settings(channel_settings), .on_screen_display(on_screen_display),
    .display_bank(display_bank), .display_position(display_position),
    .display_channel(display_channel), .adjust_up(adjust_up), .adjust_down(adjust_down)
);
`default_nettype wire

// >>> tb/front_panel_config_controller_tb_top.sv
// self-checking bench for the front-panel controller
// operator model drives the panel; bench drives jumpers and register port
`timescale 1ns/100ps
`default_nettype none
module front_panel_config_controller_tb_top
    import front_panel_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic remote_access_jumper = 1'b0;
    logic display_control_jumper = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [31:0] reg_rdata, rd;
    logic bank_indicator_led, channel_select_led, channel_code_high_led, channel_code_low_led;
    logic configuring_led, adjust_up, adjust_down;
    chan_cfg_t [3:0] channel_settings;
    logic [3:0] on_screen_display, display_position;
    logic [1:0] display_bank, display_channel;
    panel_in_t panel;
    logic [3:0] exp_cfg [4] = '{4'h2, 4'h2, 4'h2, 4'h2};
    logic [1:0] exp_ch = 2'd0;
    int fail_count = 0;
    int checked = 0;
    int configuring_led_cycles = 0;
    int up_pulses = 0;
    int dn_pulses = 0;

    always #4 clk = ~clk;

    panel_operator op_u (.clk(clk), .panel(panel));

    // short counts keep the run brief
    front_panel_config_controller #(.DEBOUNCE_CYC(21'd4), .ACCEL_CYC(26'd20), .REPEAT_CYC(26'd5),
        .CONFIGURING_LED_CYC(22'd8)) dut_u (
        .clk(clk), .rst_n(rst_n), .panel(panel), .remote_access_jumper(remote_access_jumper),
        .display_control_jumper(display_control_jumper), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .bank_indicator_led(bank_indicator_led),
        .channel_select_led(channel_select_led), .channel_code_high_led(channel_code_high_led),
        .channel_code_low_led(channel_code_low_led), .configuring_led(configuring_led),
        .channel_settings(channel_settings), .on_screen_display(on_screen_display),
        .display_bank(display_bank), .display_position(display_position),
        .display_channel(display_channel), .adjust_up(adjust_up), .adjust_down(adjust_down));

    // tallies of indicator and adjust activity, read as differences except the down tally
    always @(posedge clk) begin
        if (configuring_led === 1'b1) configuring_led_cycles <= configuring_led_cycles + 1;
        if (adjust_up === 1'b1) up_pulses <= up_pulses + 1;
        if (adjust_down === 1'b1) dn_pulses <= dn_pulses + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t mismatch got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic check_all();
        for (int i = 0; i < 4; i++) begin
            check(32'(channel_settings[i]), 32'(exp_cfg[i]));
            check(32'(on_screen_display[i]), 32'(exp_cfg[i][0] & display_control_jumper));
        end
        check({channel_code_high_led, channel_code_low_led}, 32'(exp_ch));
    endtask : check_all

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask : reg_read

    task automatic t_chsel();
        op_u.button();
        check(channel_select_led, 1'b1);
        // six steps up and one down, wrapping forward once past three, no bounce double counts
        for (int k = 0; k < 7; k++) begin
            op_u.paddle(k != 5, 0);
            exp_ch = (k == 5) ? exp_ch - 2'd1 : exp_ch + 2'd1;
            check_all();
        end
        op_u.button();
        check(channel_select_led, 1'b0);
    endtask : t_chsel

    task automatic t_functions();
        int bit_i;
        int c0;
        logic [3:0] was;
        op_u.paddle(1'b1, 0);
        check_all();
        for (int p = 1; p <= 13; p++) begin
            op_u.turn();
            case (p)
                1: bit_i = 0;
                3: bit_i = 1;
                4: bit_i = 2;
                12: bit_i = 3;
                default: bit_i = -1;
            endcase
            for (int d = 0; d < 2; d++) begin
                was = exp_cfg[exp_ch];
                if (bit_i >= 0) exp_cfg[exp_ch][bit_i] = d[0];
                c0 = configuring_led_cycles;
                op_u.paddle(d[0], 0);
                check(32'(configuring_led_cycles != c0), 32'(bit_i >= 0));
                check_all();
            end
        end
        check(configuring_led, 1'b0);
    endtask : t_functions

    task automatic t_bank_wide();
        int n0;
        repeat (3) op_u.turn();
        check(bank_indicator_led, 1'b1);
        check(32'({display_bank, display_position, display_channel}), 32'({2'd1, 4'h0, exp_ch}));
        repeat (11) op_u.turn();
        n0 = up_pulses;
        // long hold on a wide function must repeat
        op_u.paddle(1'b1, 40);
        check(32'(up_pulses - n0 >= 3), 32'h1);
        check_all();
        op_u.paddle(1'b0, 0);
        check(32'(dn_pulses), 32'h1);
    endtask : t_bank_wide

    task automatic t_jumpers();
        display_control_jumper <= 1'b0;
        repeat (4) @(posedge clk);
        check_all();
        reg_write(8'h0c, 32'h5);
        check_all();
        reg_read(8'h0c, rd);
        check(rd, 32'h2);
        reg_read(8'h00, rd);
        check(rd, 32'h5b);
        remote_access_jumper <= 1'b1;
        display_control_jumper <= 1'b1;
        reg_write(8'h0c, 32'h5);
        exp_cfg[2] = 4'h5;
        check_all();
        reg_read(8'h0c, rd);
        check(rd, 32'h5);
        reg_read(8'h40, rd);
        check(rd, 32'h0);
    endtask : t_jumpers

    task automatic test_done();
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check_all();
        check(bank_indicator_led, 1'b0);
        t_chsel();
        t_functions();
        t_bank_wide();
        t_jumpers();
        test_done();
    end

    // watchdog, well beyond the roughly 1800 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        test_done();
    end
endmodule : front_panel_config_controller_tb_top
`default_nettype wire
